// ===== dv/lasi_host.sv
/* Host processor model on the register port: write, read and poll.
   Assumes one-cycle strobes and read data visible after the strobe edge. */
module lasi_host (
   // Clock
   input  wire logic       clock,
   // Register port
   output logic      [1:0] chan_sel,
   output logic      [4:0] addr,
   output logic            wr_en,
   output logic            rd_en,
   output logic      [7:0] wr_data,
   input  wire logic [7:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      chan_sel = 2'h0;
      addr     = 5'h00;
      wr_en    = 1'b0;
      rd_en    = 1'b0;
      wr_data  = 8'h00;
   end
   task automatic write(input logic [1:0] ch, input logic [4:0] a, input logic [7:0] d);
      @(posedge clock);
      chan_sel <= ch;
      addr     <= a;
      wr_data  <= d;
      wr_en    <= 1'b1;
      @(posedge clock);
      wr_en   <= 1'b0;
      // Data released: show the inverse so stale bytes cannot pass
      wr_data <= ~d;
   endtask
   task automatic read(input logic [1:0] ch, input logic [4:0] a, output logic [7:0] d);
      @(posedge clock);
      chan_sel <= ch;
      addr     <= a;
      rd_en    <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
   endtask
   task automatic poll(input logic [1:0] ch, input logic [7:0] m, output logic [7:0] d);
      write(ch, 5'h06, m);
      read(ch, 5'h06, d);
      write(ch, 5'h06, d & m);
   endtask
endmodule

// ===== dv/lasi_top_monitor.sv
/* Concurrent checks on the ports of the alarm status and interrupt unit.
   Assumes it is bound into lasi_top and sees nothing but that module's ports. */
module lasi_top_monitor #(
   parameter int T1_WIN_CYC = 60000
) (
   // Clock and reset
   input wire logic       clock,
   input wire logic       reset_n,
   // Host register port
   input wire logic [1:0] chan_sel,
   input wire logic [4:0] addr,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic       int_n,
   // Line side
   input wire logic [3:0] tx_current_limited,
   input wire logic [3:0] tx_clock_in,
   input wire logic [3:0] tx_clock_lost
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Quiet time of channel 1 transmit clock, saturating
   // ----------------------------------------------------------------
   logic       prev_r;
   logic [7:0] still_r;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prev_r  <= 1'b0;
         still_r <= 8'h00;
      end else begin
         prev_r  <= tx_clock_in[0];
         still_r <= (tx_clock_in[0] != prev_r) ? 8'h00 : still_r + {7'h00, still_r != 8'hFF};
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence mask_wr_rd_s;
      wr_en && addr == 5'h07 ##2 rd_en && !wr_en && addr == 5'h07 && chan_sel == $past(chan_sel, 2);
   endsequence
   sequence stat_wr_rd_s;
      wr_en && addr == 5'h06 && chan_sel == 2'h0 && wr_data[2]
      ##2 rd_en && !wr_en && addr == 5'h06 && chan_sel == 2'h0;
   endsequence

   mask_readback_a: assert property (mask_wr_rd_s |=> rd_data == $past(wr_data, 3))
      else $error("mask register read differs from last write");
   live_refresh_a: assert property (stat_wr_rd_s |=> rd_data[2] == $past(tx_current_limited[0], 3))
      else $error("current limit bit not refreshed by write");
   unmapped_read_a: assert property (rd_en && addr != 5'h06 && addr != 5'h07 && addr < 5'h16 |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   rd_hold_a: assert property (!rd_en |=> $stable(rd_data))
      else $error("read data moved without a read");
   int_release_a: assert property ($rose(int_n) |-> $past(rd_en || wr_en, 1) || $past(rd_en || wr_en, 2) || $past(rd_en || wr_en, 3))
      else $error("interrupt released without host access");
   reset_quiet_a: assert property ($rose(reset_n) |-> int_n && rd_data == 8'h00 && tx_clock_lost == 4'h0)
      else $error("outputs not idle after reset");
   loss_time_a: assert property ($rose(tx_clock_lost[0]) |-> still_r >= 8'h3C && still_r <= 8'h8C)
      else $error("clock loss flagged at wrong time");
   loss_clear_a: assert property ($changed(tx_clock_in[0]) && tx_clock_lost[0] |-> ##[1:3] !tx_clock_lost[0])
      else $error("clock loss not cleared on edge");
endmodule

bind lasi_top lasi_top_monitor #(.T1_WIN_CYC(T1_WIN_CYC)) mon (.clock, .reset_n, .chan_sel,
   .addr, .wr_en, .rd_en, .wr_data, .rd_data, .int_n, .tx_current_limited, .tx_clock_in,
   .tx_clock_lost);

// ===== dv/lasi_top_tb.sv
/* Self-checking bench for the alarm status and interrupt unit.
   Assumes the host model drives the register port; the bench drives the line side. */
module lasi_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clock, reset_n, wr_en, rd_en, int_n;
   logic [1:0] chan_sel;
   logic [4:0] addr;
   logic [7:0] wr_data, rd_data;
   logic [3:0] up_code_seen, down_code_seen, tx_current_limited, tx_open_circuit;
   logic [3:0] test_pattern_seen, tx_clock_in, rx_bit_valid, rx_bit, e1_mode;
   logic [3:0] long_loss_sel, tx_clock_lost, clk_run;
   int         fails, total_checks;

   // Short all-ones window keeps the run brief
   lasi_top #(.T1_WIN_CYC(200)) uut (.clock, .reset_n, .chan_sel, .addr, .wr_en, .rd_en,
      .wr_data, .rd_data, .int_n, .up_code_seen, .down_code_seen, .tx_current_limited,
      .tx_open_circuit, .test_pattern_seen, .tx_clock_in, .rx_bit_valid, .rx_bit, .e1_mode,
      .long_loss_sel, .tx_clock_lost);
   lasi_host host (.clock, .chan_sel, .addr, .wr_en, .rd_en, .wr_data, .rd_data);

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) tx_clock_in <= tx_clock_in ^ clk_run;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic complete_run();
      if (fails == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wait_int(input logic v);
      int n;
      n = 0;
      while (int_n !== v && n < 20) begin
         @(posedge clock);
         n++;
      end
      chk("int_n", {7'h00, v}, {7'h00, int_n});
      if (int_n !== v) complete_run();
   endtask
   task automatic send_bits(input int ch, input logic b, input int n);
      repeat (n) begin
         @(posedge clock);
         rx_bit_valid[ch] <= 1'b1;
         rx_bit[ch]       <= b;
         @(posedge clock);
         rx_bit_valid[ch] <= 1'b0;
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic regs_test();
      logic [7:0] d;
      host.read(2'h1, 5'h06, d);
      chk("status reset", 8'h00, d);
      host.read(2'h2, 5'h07, d);
      chk("mask reset", 8'h00, d);
      host.write(2'h1, 5'h07, 8'hA5);
      host.read(2'h1, 5'h07, d);
      chk("mask", 8'hA5, d);
      host.read(2'h1, 5'h05, d);
      chk("unmapped", 8'h00, d);
      host.write(2'h1, 5'h07, 8'h00);
   endtask
   task automatic live_test();
      logic [7:0] d;
      @(posedge clock);
      tx_current_limited[0] <= 1'b1;
      tx_open_circuit[0]    <= 1'b1;
      test_pattern_seen[0]  <= 1'b1;
      host.poll(2'h0, 8'h04, d);
      chk("write one refresh", 8'h04, d);
      host.poll(2'h0, 8'h03, d);
      chk("live bits", 8'h07, d);
      tx_current_limited[0] <= 1'b0;
      tx_open_circuit[0]    <= 1'b0;
      test_pattern_seen[0]  <= 1'b0;
      host.poll(2'h0, 8'h07, d);
      chk("live bits off", 8'h00, d);
      chk("masked int_n", 8'h01, {7'h00, int_n});
   endtask
   task automatic event_test();
      logic [7:0] d;
      host.write(2'h2, 5'h07, 8'h80);
      @(posedge clock);
      down_code_seen[2] <= 1'b1;
      repeat (4) @(posedge clock);
      down_code_seen[2] <= 1'b0;
      repeat (4) @(posedge clock);
      chk("masked event", 8'h01, {7'h00, int_n});
      up_code_seen[2] <= 1'b1;
      repeat (4) @(posedge clock);
      up_code_seen[2] <= 1'b0;
      wait_int(1'b0);
      host.read(2'h0, 5'h1A, d);
      chk("summary", 8'h04, d & 8'h0F);
      host.poll(2'h2, 8'hC0, d);
      chk("latched codes", 8'hC0, d);
      wait_int(1'b1);
      host.poll(2'h2, 8'hC0, d);
      chk("after read", 8'h00, d);
      host.write(2'h2, 5'h07, 8'h00);
   endtask
   task automatic loss_test();
      logic [7:0] d;
      int         n;
      host.write(2'h0, 5'h07, 8'h20);
      @(posedge clock);
      clk_run[0] <= 1'b0;
      n = 0;
      while (tx_clock_lost[0] !== 1'b1 && n < 200) begin
         @(posedge clock);
         n++;
      end
      chk("loss time", 8'h01, {7'h00, n > 59 && n < 141});
      if (n == 200) complete_run();
      wait_int(1'b0);
      host.poll(2'h0, 8'h20, d);
      chk("loss bit", 8'h20, d);
      wait_int(1'b1);
      clk_run[0] <= 1'b1;
      wait_int(1'b0);
      host.poll(2'h0, 8'h20, d);
      chk("loss gone", 8'h00, d);
      wait_int(1'b1);
      host.write(2'h0, 5'h07, 8'h00);
   endtask
   task automatic carrier_test();
      logic [7:0] d;
      host.write(2'h1, 5'h07, 8'h08);
      send_bits(1, 1'b0, 254);
      chk("early loss", 8'h01, {7'h00, int_n});
      send_bits(1, 1'b0, 1);
      wait_int(1'b0);
      host.poll(2'h1, 8'h08, d);
      chk("carrier loss", 8'h08, d);
      host.poll(2'h1, 8'h08, d);
      chk("loss held", 8'h08, d);
      wait_int(1'b1);
      send_bits(1, 1'b1, 300);
      wait_int(1'b0);
      host.poll(2'h1, 8'h08, d);
      chk("carrier back", 8'h00, d);
   endtask
   task automatic ones_test();
      logic [7:0] d;
      send_bits(2, 1'b1, 512);
      host.poll(2'h2, 8'h10, d);
      chk("all ones", 8'h10, d);
      host.poll(2'h2, 8'h10, d);
      chk("all ones held", 8'h10, d);
      send_bits(2, 1'b0, 3);
      send_bits(2, 1'b1, 509);
      host.poll(2'h2, 8'h10, d);
      chk("all ones gone", 8'h00, d);
   endtask
   task automatic t1_test();
      logic [7:0] d;
      e1_mode[3]       <= 1'b0;
      long_loss_sel[3] <= 1'b1;
      host.write(2'h3, 5'h07, 8'h08);
      send_bits(3, 1'b0, 1543);
      chk("early t1 loss", 8'h01, {7'h00, int_n});
      send_bits(3, 1'b0, 1);
      wait_int(1'b0);
      host.poll(2'h3, 8'h08, d);
      chk("t1 carrier loss", 8'h08, d);
      wait_int(1'b1);
      send_bits(3, 1'b1, 112);
      wait_int(1'b0);
      host.poll(2'h3, 8'h08, d);
      chk("t1 carrier back", 8'h00, d);
      // Long enough for one whole zero-free window after the last zero
      repeat (300) @(posedge clock);
      host.poll(2'h3, 8'h10, d);
      chk("t1 all ones", 8'h10, d);
   endtask

   initial begin
      reset_n            = 1'b0;
      {up_code_seen, down_code_seen, tx_current_limited, tx_open_circuit} = 16'h0000;
      {test_pattern_seen, tx_clock_in, rx_bit_valid, rx_bit} = 16'h0000;
      e1_mode            = 4'hF;
      long_loss_sel      = 4'h0;
      clk_run            = 4'hF;
      fails              = 0;
      total_checks       = 0;
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      regs_test();
      live_test();
      event_test();
      loss_test();
      carrier_test();
      ones_test();
      t1_test();
      complete_run();
   end
endmodule

// ===== hw/lasi_pkg.sv
/*
 * Constants for the four-channel line alarm status and interrupt unit:
 * register offsets, bit positions, alarm criteria and timing counts.
 * Assumes a 20 MHz system clock; only the design module refers to names here.
 */
package lasi_pkg;

   // ----------------------------------------------------------------
   // Register map (per channel, 5-bit address)
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_STATUS   = 5'h06;
   localparam logic [4:0] ADDR_MASK     = 5'h07;
   localparam logic [4:0] ADDR_SUM_LO   = 5'h16;
   localparam logic [4:0] ADDR_SUM_HI   = 5'h1F;
   localparam logic [7:0] STATUS_RESET  = 8'h00;
   localparam logic [7:0] MASK_RESET    = 8'h00;
   localparam logic [3:0] SUM_UNUSED    = 4'h0;

   // ----------------------------------------------------------------
   // Status bit positions and classes
   // ----------------------------------------------------------------
   localparam int BIT_UP   = 7;
   localparam int BIT_DOWN = 6;
   localparam int BIT_TCL  = 5;
   localparam int BIT_UA   = 4;
   localparam int BIT_CL   = 3;
   localparam int BIT_CUR  = 2;
   localparam int BIT_OPEN = 1;
   localparam int BIT_PAT  = 0;
   // Latched bits, latched bits held while condition stays, change-of-state bits
   localparam logic [7:0] LATCH_MASK = 8'hD8;
   localparam logic [7:0] HOLD_MASK  = 8'h18;
   localparam logic [7:0] COS_MASK   = 8'h38;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS      = 50;
   localparam int TCL_LOSS_NS = 5000;
   localparam int TCL_LOSS_CYC = TCL_LOSS_NS / CLK_NS;
   localparam int T1_WIN_MS   = 3;
   localparam int T1_WIN_CYC  = (T1_WIN_MS * 1000000) / CLK_NS;

   // ----------------------------------------------------------------
   // Received alarm criteria
   // ----------------------------------------------------------------
   localparam logic [11:0] CL_E1_SHORT = 12'h0FF;
   localparam logic [11:0] CL_E1_LONG  = 12'h800;
   localparam logic [11:0] CL_T1_SHORT = 12'h0C0;
   localparam logic [11:0] CL_T1_LONG  = 12'h608;
   localparam logic [7:0]  CL_E1_WIN   = 8'hFF;
   localparam logic [7:0]  CL_T1_WIN   = 8'h70;
   localparam logic [7:0]  CL_E1_ONES  = 8'h20;
   localparam logic [7:0]  CL_T1_ONES  = 8'h0E;
   localparam logic [15:0] UA_E1_WIN   = 16'h0200;
   localparam logic [3:0]  UA_E1_SET   = 4'h2;
   localparam logic [3:0]  UA_E1_CLR   = 4'h2;
   localparam logic [3:0]  UA_T1_SET   = 4'h5;
   localparam logic [3:0]  UA_T1_CLR   = 4'h6;

endpackage

// ===== hw/lasi_top.sv
/*
 * Alarm status, interrupt mask and interrupt summary for four line
 * channels, with the carrier-loss, all-ones and transmit-clock-loss
 * detectors that feed them.
 * Assumes all inputs are synchronous to clock, received bits arrive as
 * one-cycle rx_bit_valid strobes, and the host uses one-cycle strobes.
 */

// What this block does
// RULE_01: Write 1 refreshes that status bit now
// RULE_02: Write 0 keeps that status bit unchanged
// RULE_03: Host writes mask, reads, writes back ANDed
// RULE_04: Mask bit 1 enables interrupt, 0 blocks
// RULE_05: Loss bits interrupt on every state change
// RULE_06: Loss-bit interrupt released when host reads it
// RULE_07: Other bits interrupt on set, released on read
// RULE_08: Unused addresses 16h-1Fh return channel summary
// RULE_09: Summary bits 0-3 flag channels 1-4
// RULE_10: Summary bits 7-4 unassigned, ignored by host
// RULE_11: Bit 7 latches loop-up code detection
// RULE_12: Bit 6 latches loop-down code detection
// RULE_13: Bit 5 and pin: no tx clock edge 5us
// RULE_14: E1 all-ones: under two zeros per 512
// RULE_15: T1 all-ones: five or fewer zeros per 3ms
// RULE_16: E1 carrier loss 255/2048 zeros, 32 ones clear
// RULE_17: T1 carrier loss 192/1544 zeros, 14 of 112
// RULE_18: Bit 2 shows current limiter activation live
// RULE_19: Bit 1 shows transmit open circuit live
// RULE_20: Bit 0 shows test pattern detection live
// RULE_21: Status register at 06H, loop-up bit msb
// RULE_22: Mask register at 07H, same bit order
// RULE_23: Latched bit holds until read, then clears
// RULE_24: Latched loss bits stay set while present
// RULE_25: Interrupt pin low while any unmasked pending
module lasi_top #(
   parameter int T1_WIN_CYC = lasi_pkg::T1_WIN_CYC
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // Host register port
   input  wire logic [1:0] chan_sel,
   input  wire logic [4:0] addr,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] rd_data,
   output logic            int_n,
   // Per-channel line side
   input  wire logic [3:0] up_code_seen,
   input  wire logic [3:0] down_code_seen,
   input  wire logic [3:0] tx_current_limited,
   input  wire logic [3:0] tx_open_circuit,
   input  wire logic [3:0] test_pattern_seen,
   input  wire logic [3:0] tx_clock_in,
   input  wire logic [3:0] rx_bit_valid,
   input  wire logic [3:0] rx_bit,
   input  wire logic [3:0] e1_mode,
   input  wire logic [3:0] long_loss_sel,
   output logic      [3:0] tx_clock_lost
);

   logic [7:0] status_a [0:3];
   logic [7:0] mask_a   [0:3];
   logic [3:0] chan_irq;

   // ----------------------------------------------------------------
   // Per-channel status, detectors and interrupt sources
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 4; g++) begin : g_ch
      logic        sel;
      logic        wr_status;
      logic        rd_status;
      logic [7:0]  refresh;
      logic [7:0]  cond;
      logic [7:0]  cond_q;
      logic [7:0]  rise;
      logic [7:0]  evt;
      logic [7:0]  cur;
      logic [7:0]  alarm_status_r;
      logic [7:0]  alarm_interrupt_mask_r;
      logic [7:0]  pend_r;
      logic [7:0]  ip_r;
      logic [7:0]  rmask_r;
      logic        tx_clock_in_q;
      logic [6:0]  tcl_cnt_r;
      logic        tcl_r;
      logic [11:0] zrun_r;
      logic [11:0] cl_set_thr;
      logic [7:0]  cl_win_len;
      logic [7:0]  cl_ones_thr;
      logic        cl_r;
      logic        cl_wact_r;
      logic [7:0]  cl_wcnt_r;
      logic [7:0]  cl_ones_r;
      logic [7:0]  cl_ones_sum;
      logic [15:0] ua_cnt_r;
      logic [3:0]  ua_zero_r;
      logic [3:0]  ua_sum;
      logic        ua_tick;
      logic        ua_last;
      logic        ua_r;

      assign sel       = (chan_sel == 2'(g));
      // RULE_21 status offset
      assign wr_status = wr_en && sel && (addr == lasi_pkg::ADDR_STATUS);
      assign rd_status = rd_en && sel && (addr == lasi_pkg::ADDR_STATUS);
      assign refresh   = wr_status ? wr_data : 8'h00;

      // RULE_11 RULE_12 RULE_18 RULE_19 RULE_20 source ordering
      assign cond = {up_code_seen[g], down_code_seen[g], tcl_r, ua_r, cl_r,
                     tx_current_limited[g], tx_open_circuit[g], test_pattern_seen[g]};
      assign rise = cond & ~cond_q;
      // RULE_05 change of state
      assign evt  = (cond ^ cond_q) & (lasi_pkg::COS_MASK | cond);
      // RULE_24 hold while present
      assign cur  = (cond & (~lasi_pkg::LATCH_MASK | lasi_pkg::HOLD_MASK))
                  | ((pend_r | rise) & lasi_pkg::LATCH_MASK);

      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            cond_q <= 8'h00;
         end else begin
            cond_q <= cond;
         end
      end

      // RULE_23 latch until a status write with that bit set refreshes it
      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            pend_r <= 8'h00;
         end else begin
            pend_r <= (rise | (pend_r & ~refresh)) & lasi_pkg::LATCH_MASK;
         end
      end

      // RULE_01 RULE_02 selective refresh
      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            alarm_status_r <= lasi_pkg::STATUS_RESET;
         end else begin
            alarm_status_r <= (alarm_status_r & ~refresh) | (cur & refresh);
         end
      end

      // RULE_22 mask register
      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            alarm_interrupt_mask_r <= lasi_pkg::MASK_RESET;
         end else if (wr_en && sel && addr == lasi_pkg::ADDR_MASK) begin
            alarm_interrupt_mask_r <= wr_data;
         end
      end

      // RULE_03 last written mask names the bits a read consumes
      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            rmask_r <= 8'h00;
         end else if (wr_status) begin
            rmask_r <= wr_data;
         end
      end

      // RULE_06 RULE_07 release on read, new event wins
      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            ip_r <= 8'h00;
         end else begin
            ip_r <= evt | (ip_r & ~(rd_status ? rmask_r : 8'h00));
         end
      end

      // RULE_04 mask gating
      assign chan_irq[g] = |(ip_r & alarm_interrupt_mask_r);
      assign status_a[g] = alarm_status_r;
      assign mask_a[g]   = alarm_interrupt_mask_r;

      // RULE_13 transmit clock watchdog
      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            tx_clock_in_q    <= 1'b0;
            tcl_cnt_r <= 7'h00;
            tcl_r     <= 1'b0;
         end else begin
            tx_clock_in_q <= tx_clock_in[g];
            if (tx_clock_in[g] != tx_clock_in_q) begin
               tcl_cnt_r <= 7'h00;
               tcl_r     <= 1'b0;
            end else if (tcl_cnt_r != 7'(lasi_pkg::TCL_LOSS_CYC - 1)) begin
               tcl_cnt_r <= tcl_cnt_r + 7'h01;
            end else begin
               tcl_r <= 1'b1;
            end
         end
      end
      assign tx_clock_lost[g] = tcl_r;

      // RULE_16 RULE_17 carrier-loss criteria per mode
      assign cl_set_thr  = e1_mode[g]
                         ? (long_loss_sel[g] ? lasi_pkg::CL_E1_LONG : lasi_pkg::CL_E1_SHORT)
                         : (long_loss_sel[g] ? lasi_pkg::CL_T1_LONG : lasi_pkg::CL_T1_SHORT);
      assign cl_win_len  = e1_mode[g] ? lasi_pkg::CL_E1_WIN : lasi_pkg::CL_T1_WIN;
      assign cl_ones_thr = e1_mode[g] ? lasi_pkg::CL_E1_ONES : lasi_pkg::CL_T1_ONES;
      assign cl_ones_sum = cl_ones_r + {7'h00, rx_bit[g]};

      // E1 clear windows run back to back; T1 windows open on a one
      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            zrun_r    <= 12'h000;
            cl_r      <= 1'b0;
            cl_wact_r <= 1'b0;
            cl_wcnt_r <= 8'h00;
            cl_ones_r <= 8'h00;
         end else if (rx_bit_valid[g]) begin
            if (rx_bit[g]) begin
               zrun_r <= 12'h000;
            end else if (zrun_r != 12'hFFF) begin
               zrun_r <= zrun_r + 12'h001;
            end
            if (!cl_r) begin
               cl_wact_r <= 1'b0;
               if (!rx_bit[g] && zrun_r == cl_set_thr - 12'h001) begin
                  cl_r <= 1'b1;
               end
            end else if (!cl_wact_r) begin
               if (e1_mode[g] || rx_bit[g]) begin
                  cl_wact_r <= 1'b1;
                  cl_wcnt_r <= 8'h01;
                  cl_ones_r <= {7'h00, rx_bit[g]};
               end
            end else if (cl_wcnt_r == cl_win_len - 8'h01) begin
               cl_wcnt_r <= 8'h00;
               cl_ones_r <= 8'h00;
               if (cl_ones_sum >= cl_ones_thr) begin
                  cl_r      <= 1'b0;
                  cl_wact_r <= 1'b0;
               end else begin
                  cl_wact_r <= e1_mode[g];
               end
            end else begin
               cl_wcnt_r <= cl_wcnt_r + 8'h01;
               cl_ones_r <= cl_ones_sum;
            end
         end
      end

      // RULE_14 RULE_15 all-ones windows: bits in E1, clock cycles in T1
      assign ua_tick = e1_mode[g] ? rx_bit_valid[g] : 1'b1;
      assign ua_last = e1_mode[g] ? (ua_cnt_r == lasi_pkg::UA_E1_WIN - 16'h0001)
                                  : (ua_cnt_r == 16'(T1_WIN_CYC - 1));
      // Saturate so a zero arriving on a full count cannot wrap to none
      assign ua_sum  = (ua_zero_r == 4'hF) ? 4'hF
                                           : ua_zero_r + {3'h0, rx_bit_valid[g] & ~rx_bit[g]};

      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            ua_cnt_r  <= 16'h0000;
            ua_zero_r <= 4'h0;
            ua_r      <= 1'b0;
         end else if (ua_tick && ua_last) begin
            ua_cnt_r  <= 16'h0000;
            ua_zero_r <= 4'h0;
            if (e1_mode[g]) begin
               if (ua_sum < lasi_pkg::UA_E1_SET) begin
                  ua_r <= 1'b1;
               end else if (ua_sum > lasi_pkg::UA_E1_CLR) begin
                  ua_r <= 1'b0;
               end
            end else begin
               ua_r <= (ua_sum <= lasi_pkg::UA_T1_SET) ? 1'b1 :
                       (ua_sum >= lasi_pkg::UA_T1_CLR) ? 1'b0 : ua_r;
            end
         end else begin
            if (ua_tick) begin
               ua_cnt_r <= ua_cnt_r + 16'h0001;
            end
            if (ua_zero_r != 4'hF) begin
               ua_zero_r <= ua_sum;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path and interrupt pin
   // ----------------------------------------------------------------
   // RULE_08 RULE_09 RULE_10 summary on unused range, upper bits zero
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         if (addr == lasi_pkg::ADDR_STATUS) begin
            rd_data <= status_a[chan_sel];
         end else if (addr == lasi_pkg::ADDR_MASK) begin
            rd_data <= mask_a[chan_sel];
         end else if (addr >= lasi_pkg::ADDR_SUM_LO && addr <= lasi_pkg::ADDR_SUM_HI) begin
            rd_data <= {lasi_pkg::SUM_UNUSED, chan_irq};
         end else begin
            rd_data <= 8'h00;
         end
      end
   end

   // RULE_25 wired-OR of channel requests
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         int_n <= 1'b1;
      end else begin
         int_n <= ~|chan_irq;
      end
   end

endmodule
